// ==== common/dat_defines.vh ====
// Register addresses, bit positions, reset values and divider counts of the timer pair
`ifndef DAT_DEFINES_VH
`define DAT_DEFINES_VH

// ****************************************
// Register addresses
// ****************************************
`define DAT_ADDR_CLK_CTL   8'h8E
`define DAT_ADDR_A_CTL     8'hC8
`define DAT_ADDR_A_RLD_LO  8'hCA
`define DAT_ADDR_A_RLD_HI  8'hCB
`define DAT_ADDR_A_CNT_LO  8'hCC
`define DAT_ADDR_A_CNT_HI  8'hCD
`define DAT_ADDR_B_CTL     8'h91
`define DAT_ADDR_B_RLD_LO  8'h92
`define DAT_ADDR_B_RLD_HI  8'h93
`define DAT_ADDR_B_CNT_LO  8'h94
`define DAT_ADDR_B_CNT_HI  8'h95

// ****************************************
// Control register bits
// ****************************************
`define DAT_CTL_HIGH_FLAG  7
`define DAT_CTL_LOW_FLAG   6
`define DAT_CTL_LOW_IRQ_EN 5
`define DAT_CTL_SPLIT      3
`define DAT_CTL_RUN        2
`define DAT_CTL_EXT_SEL    0
`define DAT_CTL_RW_MASK    8'hED

// ****************************************
// Clock control register bits
// ****************************************
`define DAT_CKC_B_HIGH_SYS 7
`define DAT_CKC_B_LOW_SYS  6
`define DAT_CKC_A_HIGH_SYS 5
`define DAT_CKC_A_LOW_SYS  4

// ****************************************
// Reset values and constants
// ****************************************
`define DAT_RST_BYTE       8'h00
`define DAT_BYTE_ONES      8'hFF
`define DAT_DIV12_LAST     4'hB
`define DAT_DIV12_ZERO     4'h0
`define DAT_DIV8_LAST      3'h7
`define DAT_DIV8_ZERO      3'h0
`define DAT_BYTE_ONE       8'h01

`endif

// ==== dv/dat_timers_assertions.sv ====
// Port-level checker for the timer pair
`timescale 1ns/100ps
module dat_timers_chk (
	// Clock and reset
	input wire       core_clk,
	input wire       rst_n,
	// Register port
	input wire [7:0] sfr_addr,
	input wire       sfr_wr,
	input wire       sfr_rd,
	input wire [7:0] sfr_wdata,
	input wire [7:0] sfr_rdata_r,
	// Interrupts
	input wire       timer_a_irq_enable,
	input wire       timer_b_irq_enable,
	input wire       timer_a_irq_r,
	input wire       timer_b_irq_r
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_irq_a_gate: assert property (!timer_a_irq_enable |=> !timer_a_irq_r)
		else $error("timer A request while disabled");
	chk_irq_b_gate: assert property (!timer_b_irq_enable |=> !timer_b_irq_r)
		else $error("timer B request while disabled");
	chk_flag_irq: assert property ((sfr_wr && sfr_addr == 8'hC8 && sfr_wdata[7]) ##1 timer_a_irq_enable
		|=> timer_a_irq_r) else $error("high flag gave no request");
	chk_unmapped_zero: assert property ((sfr_rd && sfr_addr < 8'h8E) |=> sfr_rdata_r == 8'h00)
		else $error("unmapped read not zero");
	chk_resv_a: assert property ((sfr_rd && sfr_addr == 8'hC8) |=> (sfr_rdata_r & 8'h12) == 8'h00)
		else $error("timer A unused bits set");
	chk_resv_b: assert property ((sfr_rd && sfr_addr == 8'h91) |=> (sfr_rdata_r & 8'h12) == 8'h00)
		else $error("timer B unused bits set");
	chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=> sfr_rdata_r == 8'h00 && !timer_a_irq_r)
		else $error("reset left state");
	chk_ctl_rw: assert property ((sfr_wr && sfr_addr == 8'hC8) ##1 !sfr_wr ##1 (sfr_rd && sfr_addr == 8'hC8)
		|=> (sfr_rdata_r & 8'h2D) == ($past(sfr_wdata, 3) & 8'h2D)) else $error("control readback wrong");
endmodule // dat_timers_chk

bind dat_timers dat_timers_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
	.timer_a_irq_enable(timer_a_irq_enable), .timer_b_irq_enable(timer_b_irq_enable),
	.timer_a_irq_r(timer_a_irq_r), .timer_b_irq_r(timer_b_irq_r));

// ==== dv/dat_timers_tb_top.sv ====
// Self-checking bench for the timer pair
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module dat_timers_tb_top;
	reg         core_clk    = 1'b0;
	reg         rst_n       = 1'b0;
	reg  [7:0]  sfr_addr    = 8'h00;
	reg         sfr_wr      = 1'b0;
	reg         sfr_rd      = 1'b0;
	reg  [7:0]  sfr_wdata   = 8'h00;
	reg  [1:0]  irq_en      = 2'h0;
	reg         ext_osc_clk = 1'b0;
	wire [7:0]  sfr_rdata_r;
	wire [1:0]  irq;
	logic [7:0] v;
	logic [7:0] ctl_adr [2] = '{8'hC8, 8'h91};
	logic [7:0] ofs [2]     = '{8'hCA, 8'h92};
	int         num_errors  = 0;
	int         check_count = 0;
	int         cyc         = 0;
	int         wr_edge     = 0;
	int         seed        = 41;

	dat_timers dut (.core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r),
		.timer_a_irq_enable(irq_en[0]), .timer_b_irq_enable(irq_en[1]), .ext_osc_clk(ext_osc_clk),
		.timer_a_irq_r(irq[0]), .timer_b_irq_r(irq[1]));

	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) cyc <= cyc + 1;

	// ****************************************
	// Model and bus tasks
	// ****************************************
	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Counter after n ticks, reloading past top
	function automatic int step(int c, int r, int n, int top);
		repeat (n) c = (c == top) ? r : c + 1;
		return c;
	endfunction
	task wr(input [7:0] a, input [7:0] d);
		@(posedge core_clk);
		#1 sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge core_clk);
		wr_edge = cyc;
		#1 sfr_wr = 1'b0;
	endtask
	task rd(input [7:0] a, output int e);
		@(posedge core_clk);
		#1 sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge core_clk);
		e = cyc;
		#1 sfr_rd = 1'b0;
		v = sfr_rdata_r;
	endtask
	task rc(input [7:0] a, input [7:0] x);
		int e;
		rd(a, e);
		`CHK($sformatf("reg %h", a), x, v)
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		test_done;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int t, e0, e, e1, n, r;
		logic [7:0] v1;
		repeat (20) @(posedge core_clk);
		#1 rst_n = 1'b1;
		rc(8'h80, 8'h00);
		rc(8'h8E, 8'h00);
		for (t = 0; t < 2; t++) begin
			rc(ctl_adr[t], 8'h00);
			for (n = 0; n < 4; n++) rc(ofs[t] + n[7:0], 8'h00);
		end
		for (t = 0; t < 2; t++) begin
			irq_en[t] = 1'b1;
			wr(ctl_adr[t], 8'hFF);
			rc(ctl_adr[t], 8'hED);
			`CHK("irq set", 1'b1, irq[t])
			wr(ctl_adr[t], 8'h00);
			rc(ctl_adr[t], 8'h00);
			`CHK("irq clear", 1'b0, irq[t])
			// 16-bit rollover from 0xFFFE on the system clock
			r = rnd();
			wr(8'h8E, 8'h30 << (2 * t));
			wr(ofs[t], r[7:0]);
			wr(ofs[t] + 8'd1, r[15:8]);
			wr(ofs[t] + 8'd2, 8'hFE);
			wr(ofs[t] + 8'd3, 8'hFF);
			wr(ctl_adr[t], 8'h24);
			e0 = wr_edge;
			rd(ofs[t] + 8'd2, e);
			n = step(32'hFFFE, r[15:0], e - e0 - 1, 32'hFFFF);
			`CHK("count low", n[7:0], v)
			rd(ofs[t] + 8'd3, e);
			n = step(32'hFFFE, r[15:0], e - e0 - 1, 32'hFFFF);
			`CHK("count high", n[15:8], v)
			rc(ctl_adr[t], 8'hE4);
			`CHK("irq 16-bit", 1'b1, irq[t])
			wr(ctl_adr[t], 8'h00);
			// Split mode, high byte halted
			wr(ofs[t] + 8'd2, 8'hFE);
			wr(ofs[t] + 8'd3, 8'hFE);
			wr(ctl_adr[t], 8'h08);
			e0 = wr_edge;
			rd(ofs[t] + 8'd2, e);
			n = step(254, r[7:0], e - e0 - 1, 255);
			`CHK("split low", n[7:0], v)
			rc(ofs[t] + 8'd3, 8'hFE);
			rc(ctl_adr[t], 8'h48);
			`CHK("irq low off", 1'b0, irq[t])
			// Park the free low counter far from its top so its flag stays clear
			wr(ofs[t] + 8'd2, 8'h00);
			wr(ctl_adr[t], 8'h0C);
			e0 = wr_edge;
			rd(ofs[t] + 8'd3, e);
			n = step(254, r[15:8], e - e0 - 1, 255);
			`CHK("split high", n[7:0], v)
			rc(ctl_adr[t], 8'h8C);
			`CHK("irq high", 1'b1, irq[t])
			// Divided sources: one tick per 12 edges, one per 8 rising pin edges
			wr(8'h8E, 8'h00);
			wr(ofs[t] + 8'd2, 8'h00);
			wr(ctl_adr[t], 8'h08);
			rd(ofs[t] + 8'd2, e1);
			v1 = v;
			repeat (118) @(posedge core_clk);
			rd(ofs[t] + 8'd2, e);
			`CHK("div12", 8'((e - e1) / 12), 8'(v - v1))
			wr(ctl_adr[t], 8'h09);
			rd(ofs[t] + 8'd2, e);
			v1 = v;
			// Pin kept at a quarter of the core rate
			repeat (32) begin
				repeat (2) @(posedge core_clk);
				#1 ext_osc_clk = ~ext_osc_clk;
			end
			repeat (8) @(posedge core_clk);
			rd(ofs[t] + 8'd2, e);
			`CHK("ext8", 8'h02, 8'(v - v1))
			wr(ctl_adr[t], 8'h00);
			irq_en[t] = 1'b0;
			$display("timer %0d done", t);
		end
		test_done;
	end
endmodule // dat_timers_tb_top

// ==== rtl/dat_timer_unit.v ====
// One auto-reload timer instance: counter bytes, reload bytes and control register
`timescale 1ns/100ps
`include "dat_defines.vh"

module dat_timer_unit (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// Count sources, one-cycle ticks
	input  wire       tick_low,
	input  wire       tick_high,
	// Register writes
	input  wire [7:0] wr_data,
	input  wire       wr_ctl,
	input  wire       wr_rld_lo,
	input  wire       wr_rld_hi,
	input  wire       wr_cnt_lo,
	input  wire       wr_cnt_hi,
	// Register contents
	output reg  [7:0] ctl_r,
	output reg  [7:0] rld_lo_r,
	output reg  [7:0] rld_hi_r,
	output reg  [7:0] cnt_lo_r,
	output reg  [7:0] cnt_hi_r
);

	reg  [7:0] cnt_lo_nxt;
	reg  [7:0] cnt_hi_nxt;
	reg        low_wrap;
	reg        high_wrap;
	reg  [7:0] ctl_nxt;
	wire       split = ctl_r[`DAT_CTL_SPLIT];
	wire       run   = ctl_r[`DAT_CTL_RUN];

	// ****************************************
	// Counting
	// ****************************************
	always @* begin
		cnt_lo_nxt = cnt_lo_r;
		cnt_hi_nxt = cnt_hi_r;
		low_wrap   = 1'b0;
		high_wrap  = 1'b0;
		if (split) begin
			if (tick_low) begin                                    // [RULE5] [RULE6]
				if (cnt_lo_r == `DAT_BYTE_ONES) begin
					low_wrap   = 1'b1;
					cnt_lo_nxt = rld_lo_r;                         // [RULE15]
				end else begin
					cnt_lo_nxt = cnt_lo_r + `DAT_BYTE_ONE;
				end
			end
			if (run && tick_high) begin                            // [RULE6]
				if (cnt_hi_r == `DAT_BYTE_ONES) begin
					high_wrap  = 1'b1;
					cnt_hi_nxt = rld_hi_r;                         // [RULE5]
				end else begin
					cnt_hi_nxt = cnt_hi_r + `DAT_BYTE_ONE;
				end
			end
		end else if (run && tick_low) begin                        // [RULE1] [RULE6]
			if (cnt_lo_r == `DAT_BYTE_ONES) begin
				low_wrap = 1'b1;                                   // [RULE4]
				if (cnt_hi_r == `DAT_BYTE_ONES) begin
					high_wrap  = 1'b1;
					cnt_lo_nxt = rld_lo_r;                         // [RULE2]
					cnt_hi_nxt = rld_hi_r;                         // [RULE2]
				end else begin
					cnt_lo_nxt = `DAT_RST_BYTE;
					cnt_hi_nxt = cnt_hi_r + `DAT_BYTE_ONE;
				end
			end else begin
				cnt_lo_nxt = cnt_lo_r + `DAT_BYTE_ONE;
			end
		end
		// A direct write wins over the count in the same cycle
		if (wr_cnt_lo)
			cnt_lo_nxt = wr_data;                                  // [RULE15]
		if (wr_cnt_hi)
			cnt_hi_nxt = wr_data;                                  // [RULE15]
	end

	// ****************************************
	// Control and flags
	// ****************************************
	always @* begin
		ctl_nxt = ctl_r;
		if (wr_ctl)
			ctl_nxt = wr_data & `DAT_CTL_RW_MASK;
		// Hardware set beats a software clear in the same cycle
		if (high_wrap)
			ctl_nxt[`DAT_CTL_HIGH_FLAG] = 1'b1;                    // [RULE2] [RULE10]
		if (low_wrap)
			ctl_nxt[`DAT_CTL_LOW_FLAG] = 1'b1;                     // [RULE10]
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			ctl_r    <= `DAT_RST_BYTE;
			rld_lo_r <= `DAT_RST_BYTE;
			rld_hi_r <= `DAT_RST_BYTE;
			cnt_lo_r <= `DAT_RST_BYTE;
			cnt_hi_r <= `DAT_RST_BYTE;
		end else begin
			ctl_r    <= ctl_nxt;
			rld_lo_r <= wr_rld_lo ? wr_data : rld_lo_r;            // [RULE15]
			rld_hi_r <= wr_rld_hi ? wr_data : rld_hi_r;            // [RULE15]
			cnt_lo_r <= cnt_lo_nxt;
			cnt_hi_r <= cnt_hi_nxt;
		end
	end

endmodule // dat_timer_unit

// ==== rtl/dat_timers.v ====
// Two auto-reload timers with their shared count sources and register port
`timescale 1ns/100ps
`include "dat_defines.vh"

// What this block does
// [RULE1] Split bit clear: one 16-bit up-counter from low and high bytes, auto-reload.
// [RULE2] 16-bit rollover to zero loads the reload pair and sets the high flag.
// [RULE3] 16-bit mode: interrupt request on every overflow when timer irq enabled.
// [RULE4] 16-bit mode: low-byte rollover also requests when low irq enable set.
// [RULE5] Split bit set: two 8-bit counters, each reloads from its own reload byte.
// [RULE6] Run bit gates whole timer in 16-bit mode; in split only the high counter.
// [RULE7] Per-byte select: set means system clock; clear uses system/12 or external/8.
// [RULE8] External divided-by-8 source is synchronised to the system clock first.
// [RULE9] External oscillator must not be faster than the system clock; the code loses rising pin edges above half the system clock.
// [RULE10] High flag on high-byte rollover; low flag on low-byte rollover in either mode.
// [RULE11] Split mode: request on high overflow, and on low overflow if low enable set.
// [RULE12] Software clears both flags itself and checks both to find the cause.
// [RULE13] Second timer behaves identically with its own control, selects and reloads.
// [RULE14] Second timer's control register has its own address, same bit layout.
// [RULE15] Reload writes take effect at next overflow; count bytes writable any time.
module dat_timers (
	// Clock and reset
	input  wire       core_clk,
	input  wire       rst_n,
	// Register port
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata_r,
	// Interrupt enables from the interrupt controller
	input  wire       timer_a_irq_enable,
	input  wire       timer_b_irq_enable,
	// External oscillator pin
	input  wire       ext_osc_clk,
	// Interrupt requests
	output reg        timer_a_irq_r,
	output reg        timer_b_irq_r
);

	// ****************************************
	// Count sources
	// ****************************************
	reg  [3:0] div12_cnt_r;
	reg        div12_tick_r;
	reg        ext_meta_r;
	reg        ext_sync_r;
	reg        ext_prev_r;
	reg  [2:0] div8_cnt_r;
	reg        ext_tick_r;
	wire       ext_rise = ext_sync_r & ~ext_prev_r;

	// System clock divided by 12
	always @(posedge core_clk) begin
		if (!rst_n) begin
			div12_cnt_r  <= `DAT_DIV12_ZERO;
			div12_tick_r <= 1'b0;
		end else begin
			div12_tick_r <= (div12_cnt_r == `DAT_DIV12_LAST);
			if (div12_cnt_r == `DAT_DIV12_LAST)
				div12_cnt_r <= `DAT_DIV12_ZERO;
			else
				div12_cnt_r <= div12_cnt_r + 4'h1;
		end
	end

	// Oscillator pin passes three flops; only the second and third are looked at.
	// Edges closer than two system clocks are lost, hence the rate limit.
	always @(posedge core_clk) begin
		if (!rst_n) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			ext_prev_r <= 1'b0;
			div8_cnt_r <= `DAT_DIV8_ZERO;
			ext_tick_r <= 1'b0;
		end else begin
			ext_meta_r <= ext_osc_clk;                             // [RULE8]
			ext_sync_r <= ext_meta_r;                              // [RULE8]
			ext_prev_r <= ext_sync_r;
			ext_tick_r <= ext_rise && (div8_cnt_r == `DAT_DIV8_LAST); // [RULE8] [RULE9]
			if (ext_rise)
				div8_cnt_r <= div8_cnt_r + 3'h1;
		end
	end

	// Picks the tick for one byte from its select bit and the timer's external select
	function sel_tick;
		input sys_sel;
		input ext_sel;
		input div12_tick;
		input ext_tick;
		begin
			if (sys_sel)
				sel_tick = 1'b1;                                   // [RULE7]
			else if (ext_sel)
				sel_tick = ext_tick;                               // [RULE7]
			else
				sel_tick = div12_tick;                             // [RULE7]
		end
	endfunction

	// Interrupt request from the flags of one timer
	function irq_of;
		input [7:0] ctl;
		input       en;
		begin
			irq_of = en & (ctl[`DAT_CTL_HIGH_FLAG] |
				(ctl[`DAT_CTL_LOW_IRQ_EN] & ctl[`DAT_CTL_LOW_FLAG]));
		end
	endfunction

	// ****************************************
	// Clock control register
	// ****************************************
	reg  [7:0] clk_ctl_r;

	always @(posedge core_clk) begin
		if (!rst_n)
			clk_ctl_r <= `DAT_RST_BYTE;
		else if (sfr_wr && sfr_addr == `DAT_ADDR_CLK_CTL)
			clk_ctl_r <= sfr_wdata;
	end

	// ****************************************
	// Timer instances
	// ****************************************
	wire [7:0] a_ctl;
	wire [7:0] a_rld_lo;
	wire [7:0] a_rld_hi;
	wire [7:0] a_cnt_lo;
	wire [7:0] a_cnt_hi;
	wire [7:0] b_ctl;
	wire [7:0] b_rld_lo;
	wire [7:0] b_rld_hi;
	wire [7:0] b_cnt_lo;
	wire [7:0] b_cnt_hi;

	wire a_tick_lo = sel_tick(clk_ctl_r[`DAT_CKC_A_LOW_SYS], a_ctl[`DAT_CTL_EXT_SEL],
		div12_tick_r, ext_tick_r);
	wire a_tick_hi = sel_tick(clk_ctl_r[`DAT_CKC_A_HIGH_SYS], a_ctl[`DAT_CTL_EXT_SEL],
		div12_tick_r, ext_tick_r);
	wire b_tick_lo = sel_tick(clk_ctl_r[`DAT_CKC_B_LOW_SYS], b_ctl[`DAT_CTL_EXT_SEL],
		div12_tick_r, ext_tick_r);
	wire b_tick_hi = sel_tick(clk_ctl_r[`DAT_CKC_B_HIGH_SYS], b_ctl[`DAT_CTL_EXT_SEL],
		div12_tick_r, ext_tick_r);

	dat_timer_unit u_timer_a (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.tick_low  (a_tick_lo),
		.tick_high (a_tick_hi),
		.wr_data   (sfr_wdata),
		.wr_ctl    (sfr_wr && sfr_addr == `DAT_ADDR_A_CTL),
		.wr_rld_lo (sfr_wr && sfr_addr == `DAT_ADDR_A_RLD_LO),
		.wr_rld_hi (sfr_wr && sfr_addr == `DAT_ADDR_A_RLD_HI),
		.wr_cnt_lo (sfr_wr && sfr_addr == `DAT_ADDR_A_CNT_LO),
		.wr_cnt_hi (sfr_wr && sfr_addr == `DAT_ADDR_A_CNT_HI),
		.ctl_r     (a_ctl),
		.rld_lo_r  (a_rld_lo),
		.rld_hi_r  (a_rld_hi),
		.cnt_lo_r  (a_cnt_lo),
		.cnt_hi_r  (a_cnt_hi)
	);

	// Same logic, own control, selects and reloads
	dat_timer_unit u_timer_b (                                     // [RULE13]
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.tick_low  (b_tick_lo),
		.tick_high (b_tick_hi),
		.wr_data   (sfr_wdata),
		.wr_ctl    (sfr_wr && sfr_addr == `DAT_ADDR_B_CTL),      // [RULE14]
		.wr_rld_lo (sfr_wr && sfr_addr == `DAT_ADDR_B_RLD_LO),
		.wr_rld_hi (sfr_wr && sfr_addr == `DAT_ADDR_B_RLD_HI),
		.wr_cnt_lo (sfr_wr && sfr_addr == `DAT_ADDR_B_CNT_LO),
		.wr_cnt_hi (sfr_wr && sfr_addr == `DAT_ADDR_B_CNT_HI),
		.ctl_r     (b_ctl),
		.rld_lo_r  (b_rld_lo),
		.rld_hi_r  (b_rld_hi),
		.cnt_lo_r  (b_cnt_lo),
		.cnt_hi_r  (b_cnt_hi)
	);

	// ****************************************
	// Read data
	// ****************************************
	reg  [7:0] rdata_nxt;

	always @* begin
		if (sfr_addr == `DAT_ADDR_CLK_CTL)
			rdata_nxt = clk_ctl_r;
		else if (sfr_addr == `DAT_ADDR_A_CTL)
			rdata_nxt = a_ctl;
		else if (sfr_addr == `DAT_ADDR_A_RLD_LO)
			rdata_nxt = a_rld_lo;
		else if (sfr_addr == `DAT_ADDR_A_RLD_HI)
			rdata_nxt = a_rld_hi;
		else if (sfr_addr == `DAT_ADDR_A_CNT_LO)
			rdata_nxt = a_cnt_lo;
		else if (sfr_addr == `DAT_ADDR_A_CNT_HI)
			rdata_nxt = a_cnt_hi;
		else if (sfr_addr == `DAT_ADDR_B_CTL)
			rdata_nxt = b_ctl;                                     // [RULE14]
		else if (sfr_addr == `DAT_ADDR_B_RLD_LO)
			rdata_nxt = b_rld_lo;
		else if (sfr_addr == `DAT_ADDR_B_RLD_HI)
			rdata_nxt = b_rld_hi;
		else if (sfr_addr == `DAT_ADDR_B_CNT_LO)
			rdata_nxt = b_cnt_lo;
		else if (sfr_addr == `DAT_ADDR_B_CNT_HI)
			rdata_nxt = b_cnt_hi;
		else
			rdata_nxt = `DAT_RST_BYTE;
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Requests stay high while the timer enable is on and the high flag, or the low flag with its irq enable bit, is set; software clearing the flag drops them
	always @(posedge core_clk) begin
		if (!rst_n) begin
			sfr_rdata_r   <= `DAT_RST_BYTE;
			timer_a_irq_r <= 1'b0;
			timer_b_irq_r <= 1'b0;
		end else begin
			if (sfr_rd)
				sfr_rdata_r <= rdata_nxt;
			timer_a_irq_r <= irq_of(a_ctl, timer_a_irq_enable);    // [RULE3] [RULE4] [RULE11] [RULE12]
			timer_b_irq_r <= irq_of(b_ctl, timer_b_irq_enable);    // [RULE13] [RULE11]
		end
	end

endmodule // dat_timers
